// ===== hw/pdc_top.sv
// pll divider and crystal loop configuration decode with divider counters
//
// Summary of operation
// RQ1 - The reference divide ratio is the 12-bit field in bits 11 to 0.
// RQ2 - The feedback ratio is bits 37 to 24, low three bits A, upper M.
// RQ3 - Post stage one, bits 17-16, divides by 1, 2, 4 or 8.
// RQ4 - Post stage two, bits 19-18, divides by 1, 3, 5 or 4.
// RQ5 - Post stage three, bits 21-20, divides by 1, 3, 5 or 4.
// RQ6 - The host writes zero into reserved bits 23 and 22.
// RQ7 - Bits 53-52 pick a crystal pump current of 1.5, 5, 8 or 24 uA.
// RQ8 - Bits 51-49 pick the crystal loop ratio; code 7 stops the oscillator.
// RQ9 - Bit 61 set turns crystal fine tuning on, clear keeps it off.
// RQ10 - Bit 54 inverts crystal tuning polarity, one for the internal one.
// RQ11 - Bit 55 set powers the crystal loop down, clear keeps it running.
// RQ12 - Bits 59-56 pick one of sixteen rising load capacitances.
`timescale 1ns/1ps
`include "pdc_consts.svh"
module pdc_top
  import pdc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // configuration word from the serial bus front end
  input wire pdc_cfg_t cfg_word,
  input wire logic cfg_load,
  // clock events
  input wire logic ref_pin,
  input wire logic vco_tick,
  input wire logic xtal_tick,
  // reference and feedback dividers
  output pdc_ref_t ref_divide_ratio,
  output pdc_fbk_t feedback_divide_ratio,
  output logic [2:0] fbk_a_count,
  output logic [10:0] fbk_m_count,
  output logic ref_div_pulse,
  output logic fbk_div_pulse,
  // post divider
  output logic [1:0] post_stage_one_sel,
  output logic [1:0] post_stage_two_sel,
  output logic [1:0] post_stage_three_sel,
  output logic [7:0] post_total_ratio,
  output logic post_div_pulse,
  // crystal loop
  output logic [1:0] xtal_loop_pump_current,
  output logic [7:0] pump_tenths_ua,
  output logic [2:0] xtal_loop_ratio_sel,
  output pdc_rom_t xtal_loop_ratio,
  output logic xtal_osc_powerdown,
  output logic xtal_fine_tune_en,
  output logic xtal_tune_polarity,
  output logic xtal_loop_powerdown,
  output logic [3:0] xtal_coarse_trim,
  output logic [11:0] load_cap_centi_pf,
  output logic xtal_div_pulse,
  output logic xtal_loop_active,
  output logic fine_tune_active,
  // status
  output logic cfg_reserved_err
);

  // shared table of the two odd-ratio post stages
  function automatic pdc_ratio_t odd_stage_ratio(input logic [1:0] sel);
    pdc_ratio_t r;
    r = `PDC_DIV_1;
    unique case (sel)
      2'h0: r = `PDC_DIV_1;
      2'h1: r = `PDC_DIV_3;
      2'h2: r = `PDC_DIV_5;
      2'h3: r = `PDC_DIV_4;
    endcase
    return r;
  endfunction : odd_stage_ratio

  // ------------- configuration latch
  pdc_cfg_t cfg_q;
  pdc_cfg_t cfg_d;
  logic restart_q;
  logic restart_d;

  always_comb begin
    cfg_d = cfg_q;
    restart_d = 1'b0;
    if (cfg_load) begin
      cfg_d = cfg_word;
      // counters restart so a new ratio never sees a stale count
      restart_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_q <= `PDC_CFG_RESET;
      restart_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      restart_q <= restart_d;
    end
  end

  // ------------- field decode
  pdc_ref_t ref_ratio;
  pdc_fbk_t fbk_ratio;
  logic [1:0] post_sel [0:2];
  pdc_ratio_t stage_ratio [0:2];
  logic [7:0] total_d;
  logic [7:0] pump_d;
  logic fine_req;
  logic xlpd;
  logic osc_off;
  pdc_rom_t rom_ratio;
  logic [11:0] cap_d;

  assign ref_ratio = cfg_q[`PDC_REF_HI:`PDC_REF_LO]; // RQ1
  assign fbk_ratio = cfg_q[`PDC_FBK_HI:`PDC_FBK_LO]; // RQ2
  assign post_sel[0] = cfg_q[`PDC_PS1_HI:`PDC_PS1_LO];
  assign post_sel[1] = cfg_q[`PDC_PS2_HI:`PDC_PS2_LO];
  assign post_sel[2] = cfg_q[`PDC_PS3_HI:`PDC_PS3_LO];
  assign fine_req = cfg_q[`PDC_FINE_BIT];
  assign xlpd = cfg_q[`PDC_XPD_BIT];

  always_comb begin
    stage_ratio[0] = `PDC_DIV_1;
    unique case (post_sel[0]) // RQ3
      2'h0: stage_ratio[0] = `PDC_DIV_1;
      2'h1: stage_ratio[0] = `PDC_DIV_2;
      2'h2: stage_ratio[0] = `PDC_DIV_4;
      2'h3: stage_ratio[0] = `PDC_DIV_8;
    endcase
    stage_ratio[1] = odd_stage_ratio(post_sel[1]); // RQ4
    stage_ratio[2] = odd_stage_ratio(post_sel[2]); // RQ5
    // widen each factor first: 8 * 5 * 5 does not fit in four bits
    total_d = 8'(stage_ratio[0]) * 8'(stage_ratio[1]) * 8'(stage_ratio[2]);
  end

  always_comb begin
    pump_d = `PDC_PUMP_1U5;
    unique case (cfg_q[`PDC_PUMP_HI:`PDC_PUMP_LO]) // RQ7
      2'h0: pump_d = `PDC_PUMP_1U5;
      2'h1: pump_d = `PDC_PUMP_5U;
      2'h2: pump_d = `PDC_PUMP_8U;
      2'h3: pump_d = `PDC_PUMP_24U;
    endcase
  end

  pdc_xtal_rom u_rom (
    .ratio_sel(cfg_q[`PDC_ROM_HI:`PDC_ROM_LO]), // RQ8
    .trim(cfg_q[`PDC_TRIM_HI:`PDC_TRIM_LO]), // RQ12
    .ratio(rom_ratio),
    .osc_off(osc_off),
    .cap_centi_pf(cap_d)
  );

  // registered copies of every decoded field
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ref_divide_ratio <= 12'h000;
      feedback_divide_ratio <= 14'h0000;
      fbk_a_count <= 3'h0;
      fbk_m_count <= 11'h000;
      post_stage_one_sel <= 2'h0;
      post_stage_two_sel <= 2'h0;
      post_stage_three_sel <= 2'h0;
      post_total_ratio <= `PDC_TOTAL_RESET;
      xtal_loop_pump_current <= 2'h0;
      pump_tenths_ua <= `PDC_PUMP_1U5;
      xtal_loop_ratio_sel <= 3'h0;
      xtal_loop_ratio <= `PDC_ROM_R0;
      xtal_osc_powerdown <= 1'b0;
      xtal_fine_tune_en <= 1'b0;
      xtal_tune_polarity <= 1'b0;
      xtal_loop_powerdown <= 1'b0;
      xtal_coarse_trim <= 4'h0;
      load_cap_centi_pf <= `PDC_CAP_0;
      cfg_reserved_err <= 1'b0;
    end else begin
      ref_divide_ratio <= ref_ratio; // RQ1
      feedback_divide_ratio <= fbk_ratio; // RQ2
      fbk_a_count <= fbk_ratio[`PDC_FBK_A_HI:`PDC_FBK_A_LO]; // RQ2
      fbk_m_count <= fbk_ratio[`PDC_FBK_M_HI:`PDC_FBK_M_LO]; // RQ2
      post_stage_one_sel <= post_sel[0];
      post_stage_two_sel <= post_sel[1];
      post_stage_three_sel <= post_sel[2];
      post_total_ratio <= total_d;
      xtal_loop_pump_current <= cfg_q[`PDC_PUMP_HI:`PDC_PUMP_LO]; // RQ7
      pump_tenths_ua <= pump_d; // RQ7
      xtal_loop_ratio_sel <= cfg_q[`PDC_ROM_HI:`PDC_ROM_LO]; // RQ8
      xtal_loop_ratio <= rom_ratio; // RQ8
      xtal_osc_powerdown <= osc_off; // RQ8
      xtal_fine_tune_en <= fine_req; // RQ9
      xtal_tune_polarity <= cfg_q[`PDC_POL_BIT]; // RQ10
      xtal_loop_powerdown <= xlpd; // RQ11
      xtal_coarse_trim <= cfg_q[`PDC_TRIM_HI:`PDC_TRIM_LO]; // RQ12
      load_cap_centi_pf <= cap_d; // RQ12
      // flagged only; a host breaking this is not corrected
      cfg_reserved_err <= |cfg_q[`PDC_RSV_HI:`PDC_RSV_LO]; // RQ6
    end
  end

  // ------------- ref pin synchroniser
  logic ref_meta_q;
  logic ref_sync_q;
  logic ref_prev_q;
  logic ref_edge;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      ref_meta_q <= ref_pin;
      ref_sync_q <= ref_meta_q;
      ref_prev_q <= ref_sync_q;
    end
  end

  assign ref_edge = ref_sync_q & ~ref_prev_q;

  // ------------- reference and feedback dividers
  // a ratio of zero is treated as one; pins limited to core_clk/2 edges
  logic [11:0] ref_cnt_q;
  logic [11:0] ref_cnt_d;
  logic ref_pls_q;
  logic ref_pls_d;
  logic [13:0] fbk_cnt_q;
  logic [13:0] fbk_cnt_d;
  logic fbk_pls_q;
  logic fbk_pls_d;
  logic post_tick;

  always_comb begin
    ref_cnt_d = ref_cnt_q;
    ref_pls_d = 1'b0;
    fbk_cnt_d = fbk_cnt_q;
    fbk_pls_d = 1'b0;
    if (restart_q) begin
      ref_cnt_d = 12'h000;
      fbk_cnt_d = 14'h0000;
    end else begin
      if (ref_edge) begin
        if (12'(ref_cnt_q + 12'h001) >= ref_ratio) begin // RQ1
          ref_cnt_d = 12'h000;
          ref_pls_d = 1'b1;
        end else begin
          ref_cnt_d = 12'(ref_cnt_q + 12'h001);
        end
      end
      if (post_tick) begin
        if (14'(fbk_cnt_q + 14'h0001) >= fbk_ratio) begin // RQ2
          fbk_cnt_d = 14'h0000;
          fbk_pls_d = 1'b1;
        end else begin
          fbk_cnt_d = 14'(fbk_cnt_q + 14'h0001);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ref_cnt_q <= 12'h000;
      ref_pls_q <= 1'b0;
      fbk_cnt_q <= 14'h0000;
      fbk_pls_q <= 1'b0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      ref_pls_q <= ref_pls_d;
      fbk_cnt_q <= fbk_cnt_d;
      fbk_pls_q <= fbk_pls_d;
    end
  end

  assign ref_div_pulse = ref_pls_q;
  assign fbk_div_pulse = fbk_pls_q;

  // ------------- cascaded post dividers
  logic stage_tick [0:3];

  assign stage_tick[0] = vco_tick;

  for (genvar g = 0; g < 3; g++) begin : g_post
    pdc_post_div u_stage (
      .core_clk(core_clk),
      .reset(reset),
      .restart(restart_q),
      .ratio(stage_ratio[g]), // RQ3 RQ4 RQ5
      .tick_in(stage_tick[g]),
      .tick_out(stage_tick[g+1])
    );
  end

  assign post_tick = stage_tick[3];
  assign post_div_pulse = stage_tick[3];

  // ------------- crystal loop divider and run state
  pdc_xl_state_t xl_q;
  pdc_xl_state_t xl_d;
  logic [11:0] xl_cnt_q;
  logic [11:0] xl_cnt_d;
  logic xl_pls_q;
  logic xl_pls_d;
  logic xl_stop;

  // either power-down stops the divider outright
  assign xl_stop = xlpd | osc_off; // RQ8 RQ11

  always_comb begin
    xl_d = xl_q;
    xl_cnt_d = xl_cnt_q;
    xl_pls_d = 1'b0;
    if (xl_stop || restart_q) begin
      xl_cnt_d = 12'h000;
    end else if (xtal_tick) begin
      if (12'(xl_cnt_q + 12'h001) >= rom_ratio) begin // RQ8
        xl_cnt_d = 12'h000;
        xl_pls_d = 1'b1;
      end else begin
        xl_cnt_d = 12'(xl_cnt_q + 12'h001);
      end
    end
    unique case (xl_q)
      PDC_XL_OFF: begin
        if (!xl_stop) begin
          xl_d = PDC_XL_START;
        end
      end
      PDC_XL_START: begin
        if (xl_stop) begin
          xl_d = PDC_XL_OFF; // RQ11
        end else if (xl_pls_q) begin
          xl_d = PDC_XL_RUN;
        end
      end
      PDC_XL_RUN: begin
        if (xl_stop) begin
          xl_d = PDC_XL_OFF; // RQ11
        end
      end
      default: xl_d = PDC_XL_OFF;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      xl_q <= PDC_XL_OFF;
      xl_cnt_q <= 12'h000;
      xl_pls_q <= 1'b0;
    end else begin
      xl_q <= xl_d;
      xl_cnt_q <= xl_cnt_d;
      xl_pls_q <= xl_pls_d;
    end
  end

  assign xtal_div_pulse = xl_pls_q;
  assign xtal_loop_active = (xl_q == PDC_XL_RUN);
  // fine tune only acts while the loop is up and enabled
  assign fine_tune_active = xtal_fine_tune_en & (xl_q == PDC_XL_RUN); // RQ9

endmodule : pdc_top

// ===== hw/pdc_consts.svh
// named field positions, encodings and reset values of the pll config word
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

`define PDC_CFG_RESET 64'h0000_0000_0000_0000
`define PDC_REF_HI 11
`define PDC_REF_LO 0
`define PDC_FBK_HI 37
`define PDC_FBK_LO 24
`define PDC_FBK_A_HI 2
`define PDC_FBK_A_LO 0
`define PDC_FBK_M_HI 13
`define PDC_FBK_M_LO 3
`define PDC_PS1_HI 17
`define PDC_PS1_LO 16
`define PDC_PS2_HI 19
`define PDC_PS2_LO 18
`define PDC_PS3_HI 21
`define PDC_PS3_LO 20
`define PDC_RSV_HI 23
`define PDC_RSV_LO 22
`define PDC_ROM_HI 51
`define PDC_ROM_LO 49
`define PDC_PUMP_HI 53
`define PDC_PUMP_LO 52
`define PDC_POL_BIT 54
`define PDC_XPD_BIT 55
`define PDC_TRIM_HI 59
`define PDC_TRIM_LO 56
`define PDC_FINE_BIT 61

// post divider ratios
`define PDC_DIV_1 4'h1
`define PDC_DIV_2 4'h2
`define PDC_DIV_3 4'h3
`define PDC_DIV_4 4'h4
`define PDC_DIV_5 4'h5
`define PDC_DIV_8 4'h8
`define PDC_TOTAL_RESET 8'h01

// pump current in tenths of a microamp
`define PDC_PUMP_1U5 8'h0F
`define PDC_PUMP_5U 8'h32
`define PDC_PUMP_8U 8'h50
`define PDC_PUMP_24U 8'hF0

// crystal loop divider rom
`define PDC_ROM_R0 12'h001
`define PDC_ROM_R1 12'hC00
`define PDC_ROM_R2 12'hC54
`define PDC_ROM_R3 12'h97E
`define PDC_ROM_R4 12'h9C4
`define PDC_ROM_R5 12'hFA0
`define PDC_ROM_R6 12'hD2F
`define PDC_ROM_OFF 3'h7

// load capacitance in hundredths of a picofarad
`define PDC_CAP_0 12'h3E8
`define PDC_CAP_1 12'h43C
`define PDC_CAP_2 12'h491
`define PDC_CAP_3 12'h4E5
`define PDC_CAP_4 12'h53A
`define PDC_CAP_5 12'h58E
`define PDC_CAP_6 12'h5E2
`define PDC_CAP_7 12'h637
`define PDC_CAP_8 12'h68B
`define PDC_CAP_9 12'h6DF
`define PDC_CAP_A 12'h733
`define PDC_CAP_B 12'h788
`define PDC_CAP_C 12'h7DD
`define PDC_CAP_D 12'h831
`define PDC_CAP_E 12'h885
`define PDC_CAP_F 12'h8DA

`endif

// ===== hw/pdc_pkg.sv
// types shared by the pll divider configuration block
package pdc_pkg;

  typedef logic [63:0] pdc_cfg_t;
  typedef logic [11:0] pdc_ref_t;
  typedef logic [13:0] pdc_fbk_t;
  typedef logic [3:0] pdc_ratio_t;
  typedef logic [11:0] pdc_rom_t;

  typedef enum logic [1:0] {
    PDC_XL_OFF = 2'b00,
    PDC_XL_START = 2'b01,
    PDC_XL_RUN = 2'b11
  } pdc_xl_state_t;

endpackage : pdc_pkg

// ===== hw/pdc_post_div.sv
// one post divider stage: passes every n-th input tick
`timescale 1ns/1ps
`include "pdc_consts.svh"
module pdc_post_div
  import pdc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic restart,
  input wire pdc_ratio_t ratio,
  // ticks
  input wire logic tick_in,
  output logic tick_out
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic out_q;
  logic out_d;
  logic [2:0] last;

  assign last = 3'(ratio - `PDC_DIV_1);

  always_comb begin
    cnt_d = cnt_q;
    out_d = 1'b0;
    if (restart) begin
      cnt_d = 3'h0;
    end else if (tick_in) begin
      if (cnt_q >= last) begin
        cnt_d = 3'h0;
        out_d = 1'b1;
      end else begin
        cnt_d = 3'(cnt_q + 3'h1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= 3'h0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign tick_out = out_q;

endmodule : pdc_post_div

// ===== hw/pdc_xtal_rom.sv
// crystal loop divider rom and coarse load capacitance lookup
`timescale 1ns/1ps
`include "pdc_consts.svh"
module pdc_xtal_rom
  import pdc_pkg::*;
(
  // selections
  input wire logic [2:0] ratio_sel,
  input wire logic [3:0] trim,
  // lookups
  output pdc_rom_t ratio,
  output logic osc_off,
  output logic [11:0] cap_centi_pf
);

  always_comb begin
    osc_off = 1'b0;
    unique case (ratio_sel)
      3'h0: ratio = `PDC_ROM_R0;
      3'h1: ratio = `PDC_ROM_R1;
      3'h2: ratio = `PDC_ROM_R2;
      3'h3: ratio = `PDC_ROM_R3;
      3'h4: ratio = `PDC_ROM_R4;
      3'h5: ratio = `PDC_ROM_R5;
      3'h6: ratio = `PDC_ROM_R6;
      3'h7: begin
        // oscillator off: ratio reads R0, divider cleared to zero and stopped
        ratio = `PDC_ROM_R0;
        osc_off = 1'b1;
      end
    endcase
  end

  always_comb begin
    unique case (trim)
      4'h0: cap_centi_pf = `PDC_CAP_0;
      4'h1: cap_centi_pf = `PDC_CAP_1;
      4'h2: cap_centi_pf = `PDC_CAP_2;
      4'h3: cap_centi_pf = `PDC_CAP_3;
      4'h4: cap_centi_pf = `PDC_CAP_4;
      4'h5: cap_centi_pf = `PDC_CAP_5;
      4'h6: cap_centi_pf = `PDC_CAP_6;
      4'h7: cap_centi_pf = `PDC_CAP_7;
      4'h8: cap_centi_pf = `PDC_CAP_8;
      4'h9: cap_centi_pf = `PDC_CAP_9;
      4'hA: cap_centi_pf = `PDC_CAP_A;
      4'hB: cap_centi_pf = `PDC_CAP_B;
      4'hC: cap_centi_pf = `PDC_CAP_C;
      4'hD: cap_centi_pf = `PDC_CAP_D;
      4'hE: cap_centi_pf = `PDC_CAP_E;
      4'hF: cap_centi_pf = `PDC_CAP_F;
    endcase
  end

endmodule : pdc_xtal_rom

// ===== verif/pdc_top_checker.sv
// assertions on the configuration decode ports of pdc_top
`timescale 1ns/1ps
module pdc_top_checker
  import pdc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // load
  input wire pdc_cfg_t cfg_word,
  input wire logic cfg_load,
  // decoded fields
  input wire pdc_ref_t ref_divide_ratio,
  input wire logic [2:0] fbk_a_count,
  input wire logic [10:0] fbk_m_count,
  input wire logic [1:0] post_stage_one_sel,
  input wire logic [1:0] post_stage_two_sel,
  input wire logic [1:0] post_stage_three_sel,
  input wire logic [7:0] post_total_ratio,
  input wire logic [1:0] xtal_loop_pump_current,
  input wire logic [7:0] pump_tenths_ua,
  input wire logic [2:0] xtal_loop_ratio_sel,
  input wire logic xtal_osc_powerdown,
  input wire logic xtal_fine_tune_en,
  input wire logic xtal_tune_polarity,
  input wire logic xtal_loop_powerdown,
  input wire logic [3:0] xtal_coarse_trim,
  input wire logic [11:0] load_cap_centi_pf,
  input wire logic xtal_loop_active,
  input wire logic fine_tune_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // word as it stood two edges ago, when the decode shows it
  pdc_cfg_t w1_q;
  pdc_cfg_t w2_q;
  always_ff @(posedge core_clk) begin
    w1_q <= cfg_word;
    w2_q <= w1_q;
  end

  function automatic logic [7:0] f23(input logic [1:0] c);
    return (c == 2'h0) ? 8'h01 : (c == 2'h1) ? 8'h03 :
      (c == 2'h2) ? 8'h05 : 8'h04;
  endfunction : f23

  property p_ref;
    cfg_load |-> ##2 ref_divide_ratio == w2_q[11:0];
  endproperty
  a_ref: assert property (p_ref) else $error("reference ratio wrong");
  property p_fbk;
    cfg_load |-> ##2 {fbk_m_count, fbk_a_count} == w2_q[37:24];
  endproperty
  a_fbk: assert property (p_fbk) else $error("feedback split wrong");
  property p_sel;
    cfg_load |-> ##2 {post_stage_three_sel, post_stage_two_sel,
      post_stage_one_sel} == w2_q[21:16];
  endproperty
  a_sel: assert property (p_sel) else $error("post select");
  property p_total;
    post_total_ratio == (8'h01 << post_stage_one_sel) *
      f23(post_stage_two_sel) * f23(post_stage_three_sel);
  endproperty
  a_total: assert property (p_total) else $error("post ratio");
  property p_pump;
    pump_tenths_ua == ((xtal_loop_pump_current == 2'h0) ? 8'h0F :
      (xtal_loop_pump_current == 2'h1) ? 8'h32 :
      (xtal_loop_pump_current == 2'h2) ? 8'h50 : 8'hF0);
  endproperty
  a_pump: assert property (p_pump) else $error("pump current wrong");
  property p_rom;
    cfg_load |-> ##2 xtal_loop_ratio_sel == w2_q[51:49] &&
      xtal_osc_powerdown == (w2_q[51:49] == 3'h7);
  endproperty
  a_rom: assert property (p_rom) else $error("rom select wrong");
  property p_fine;
    fine_tune_active == (xtal_fine_tune_en && xtal_loop_active);
  endproperty
  a_fine: assert property (p_fine) else $error("fine tune wrong");
  property p_pol;
    cfg_load |-> ##2 xtal_tune_polarity == w2_q[54] &&
      xtal_fine_tune_en == w2_q[61];
  endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong");
  property p_xpd;
    xtal_loop_powerdown |-> ##1 !xtal_loop_active;
  endproperty
  a_xpd: assert property (p_xpd) else $error("loop still active");
  property p_cap;
    xtal_coarse_trim > $past(xtal_coarse_trim) |->
      load_cap_centi_pf > $past(load_cap_centi_pf);
  endproperty
  a_cap: assert property (p_cap) else $error("capacitance not rising");

  c_b2b: cover property (cfg_load ##1 cfg_load);
  c_run: cover property (fine_tune_active);
  c_off: cover property (xtal_osc_powerdown);
endmodule : pdc_top_checker

bind pdc_top pdc_top_checker u_chk (.*);

// ===== verif/pdc_host_model.sv
// serial host model that hands over whole configuration words
`timescale 1ns/1ps
module pdc_host_model
  import pdc_pkg::*;
(
  // clock
  input wire logic core_clk,
  // configuration
  output pdc_cfg_t cfg_word,
  output logic cfg_load
);
  initial begin
    cfg_word = 64'h0;
    cfg_load = 1'b0;
  end
  // entered just after an edge; bad keeps the reserved bits as given
  task automatic send(input pdc_cfg_t w, input logic bad);
    cfg_word = bad ? w : w & ~64'h0000_0000_00C0_0000;
    cfg_load = 1'b1;
    @(posedge core_clk);
    #1;
  endtask : send
  // word no longer held once the load is gone
  task automatic idle();
    cfg_load = 1'b0;
    cfg_word = ~cfg_word;
  endtask : idle
endmodule : pdc_host_model

// ===== verif/pdc_top_tb_top.sv
// self-checking bench for the pll divider configuration block
`timescale 1ns/1ps
module pdc_top_tb_top;
  import pdc_pkg::*;
  logic core_clk, reset, cfg_load, ref_pin, vco_tick, xtal_tick;
  pdc_cfg_t cfg_word;
  pdc_ref_t ref_divide_ratio;
  pdc_fbk_t feedback_divide_ratio;
  pdc_rom_t xtal_loop_ratio;
  logic [2:0] fbk_a_count, xtal_loop_ratio_sel;
  logic [10:0] fbk_m_count;
  logic [1:0] post_stage_one_sel, post_stage_two_sel, post_stage_three_sel;
  logic [1:0] xtal_loop_pump_current;
  logic [7:0] post_total_ratio, pump_tenths_ua;
  logic [3:0] xtal_coarse_trim;
  logic [11:0] load_cap_centi_pf;
  logic ref_div_pulse, fbk_div_pulse, post_div_pulse, xtal_div_pulse;
  logic xtal_osc_powerdown, xtal_fine_tune_en, xtal_tune_polarity;
  logic xtal_loop_powerdown, xtal_loop_active, fine_tune_active;
  logic cfg_reserved_err;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] seed;
  logic [15:0] n_r, n_f, n_p, n_x;
  logic [99:0] exp_q[$];
  logic [1:0] pipe = 2'b00;
  logic [7:0] pump_t [4] = '{8'h0F, 8'h32, 8'h50, 8'hF0};
  logic [7:0] d23_t [4] = '{8'h01, 8'h03, 8'h05, 8'h04};
  logic [11:0] rom_t [8] = '{12'h001, 12'hC00, 12'hC54, 12'h97E, 12'h9C4,
    12'hFA0, 12'hD2F, 12'h001};
  logic [11:0] cap_t [16] = '{12'h3E8, 12'h43C, 12'h491, 12'h4E5, 12'h53A,
    12'h58E, 12'h5E2, 12'h637, 12'h68B, 12'h6DF, 12'h733, 12'h788, 12'h7DD,
    12'h831, 12'h885, 12'h8DA};
  pdc_cfg_t w;

  pdc_top dut (.*);
  pdc_host_model u_host (.core_clk, .cfg_word, .cfg_load);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [99:0] exp_of(input pdc_cfg_t v);
    logic [7:0] t;
    t = (8'h01 << v[17:16]) * d23_t[v[19:18]] * d23_t[v[21:20]];
    return {v[11:0], v[37:24], v[26:24], v[37:27], v[21:16], t, v[53:52],
      pump_t[v[53:52]], v[51:49], rom_t[v[51:49]], &v[51:49], v[61], v[54],
      v[55], v[59:56], cap_t[v[59:56]], |v[23:22]};
  endfunction : exp_of

  task automatic cmp_dec(input logic [99:0] e, input logic [99:0] a);
    samples_checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask : cmp_dec

  task automatic cmp_cnt(input logic [15:0] e, input logic [15:0] a);
    samples_checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask : cmp_cnt

  task automatic load(input pdc_cfg_t v, input logic bad);
    exp_q.push_back(exp_of(bad ? v : v & ~64'h0000_0000_00C0_0000));
    u_host.send(v, bad);
  endtask : load

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // decode shows two edges after the load edge
  always @(posedge core_clk) begin
    if (pipe[1]) begin
      cmp_dec(exp_q.pop_front(), {ref_divide_ratio, feedback_divide_ratio,
        fbk_a_count, fbk_m_count, post_stage_three_sel, post_stage_two_sel,
        post_stage_one_sel, post_total_ratio, xtal_loop_pump_current,
        pump_tenths_ua, xtal_loop_ratio_sel, xtal_loop_ratio,
        xtal_osc_powerdown, xtal_fine_tune_en, xtal_tune_polarity,
        xtal_loop_powerdown, xtal_coarse_trim, load_cap_centi_pf,
        cfg_reserved_err});
    end
    pipe = reset ? 2'b00 : {pipe[0], cfg_load};
    n_r += ref_div_pulse;
    n_f += fbk_div_pulse;
    n_p += post_div_pulse;
    n_x += xtal_div_pulse;
  end

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    ref_pin = 1'b0;
    vco_tick = 1'b0;
    xtal_tick = 1'b0;
    seed = 32'h68C5280B;
    repeat (6) @(posedge core_clk);
    #1 reset = 1'b0;
    // back-to-back loads walking every post, pump, ratio and trim code
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      w[31:0] = seed;
      seed = lfsr(seed);
      w[63:32] = seed;
      w[21:16] = {i[2:1], i[3:2], i[1:0]};
      w[53:49] = {i[1:0], i[2:0]};
      w[59:56] = i[3:0];
      load(w, 1'b0);
    end
    load(64'h0000_0000_00C0_0000, 1'b1);
    u_host.idle();
    // counting: ref 3, post 2*3*1, feedback 2, crystal ratio 1, fine on
    load(64'h2000_0000_0205_0003, 1'b0);
    u_host.idle();
    repeat (3) @(posedge core_clk);
    #1 {n_r, n_f, n_p, n_x} = 64'h0;
    vco_tick = 1'b1;
    xtal_tick = 1'b1;
    repeat (60) begin
      ref_pin = ~ref_pin;
      @(posedge core_clk);
      #1;
    end
    vco_tick = 1'b0;
    xtal_tick = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 cmp_cnt(16'h000A, n_r);
    cmp_cnt(16'h000A, n_p);
    cmp_cnt(16'h0005, n_f);
    cmp_cnt(16'h003C, n_x);
    cmp_cnt(16'h0001, {15'h0, fine_tune_active});
    // loop power-down, then oscillator power-down by ratio code 7
    for (int k = 0; k < 2; k++) begin
      load(k ? 64'h200E_0000_0205_0003 : 64'h2080_0000_0205_0003, 1'b0);
      u_host.idle();
      repeat (3) @(posedge core_clk);
      #1 n_x = 16'h0;
      xtal_tick = 1'b1;
      repeat (10) @(posedge core_clk);
      #1 xtal_tick = 1'b0;
      repeat (5) @(posedge core_clk);
      #1 cmp_cnt(16'h0000, n_x);
      cmp_cnt(16'h0000, {14'h0, xtal_loop_active, fine_tune_active});
    end
    final_report();
  end
endmodule : pdc_top_tb_top
